// >>> hw/ext_exp_pkg.sv
// Constants and carrier types for the external memory expansion controller
package ext_exp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MAP = 8'h00;
  localparam logic [7:0] OFF_LOW_OUT = 8'h04;
  localparam logic [7:0] OFF_UP_OUT = 8'h08;
  localparam logic [7:0] OFF_UP_DIR = 8'h0c;
  localparam logic [7:0] OFF_PINS = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // Mapping register fields and reset values
  // ----------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int RAM_EN_BIT = 3;
  localparam logic [7:0] PORT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Mode field encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_SC_IN = 3'h0;
  localparam logic [2:0] MODE_SC_OUT = 3'h1;
  localparam logic [2:0] MODE_EXP_256 = 3'h2;
  localparam logic [2:0] MODE_EXP_4K = 3'h4;
  localparam logic [2:0] MODE_EXP_16K = 3'h6;
  localparam logic [2:0] MODE_EXP_FULL = 3'h7;

  // ----------------------------------------------------------------
  // Address masks and upper pin counts per mode
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_256 = 16'h00ff;
  localparam logic [15:0] MASK_4K = 16'h0fff;
  localparam logic [15:0] MASK_16K = 16'h3fff;
  localparam logic [15:0] MASK_FULL = 16'hffff;
  localparam logic [3:0] PINS_256 = 4'h0;
  localparam logic [3:0] PINS_4K = 4'h4;
  localparam logic [3:0] PINS_16K = 4'h6;
  localparam logic [3:0] PINS_FULL = 4'h8;

  // ----------------------------------------------------------------
  // External region defaults and idle read value
  // ----------------------------------------------------------------
  localparam logic [15:0] EXT_BASE_DEF = 16'h8000;
  localparam logic [15:0] EXT_TOP_DEF = 16'hfbff;
  localparam logic [7:0] NO_BUS_DATA = 8'hff;

  // ----------------------------------------------------------------
  // Core side carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] rdata;
  } core_resp_t;

endpackage

// >>> hw/ext_mem_expansion.sv
// External memory expansion controller with register bus slave
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps

// How it works
// - External region accesses go onto external bus
// - Lower port carries address then data byte
// - 256-byte mode: no upper address pins
// - 4K mode: four low upper pins carry address
// - 16K mode: six low upper pins carry address
// - Full mode: all upper pins carry address
// - Unassigned upper pins stay general ports
// - External address is internal address modulo size
// - Mode field selects lower port use, direction
// - Reset or hardware stop clears mode field
// - Address driven on bus every machine cycle
// - Strobes only during memory cycles
// - Eight-bit mapping register holds mode, RAM enable
// - Mode encodings 000,001,010,100,110,111
// - RAM enable bit keeps value across reset
module ext_mem_expansion
  import ext_exp_pkg::*;
#(
  parameter logic [15:0] EXT_BASE = EXT_BASE_DEF,
  parameter logic [15:0] EXT_TOP = EXT_TOP_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hw_stop,
  input wire core_req_t core_req,
  output core_resp_t core_resp,
  output logic onchip_ram_enable,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] muxed_bus_port_pins_i,
  output logic [7:0] muxed_bus_port_pins_o,
  output logic [7:0] muxed_bus_port_pins_oe_n,
  input wire logic [7:0] upper_address_port_pins_i,
  output logic [7:0] upper_address_port_pins_o,
  output logic [7:0] upper_address_port_pins_oe_n,
  output logic ale,
  output logic rd_strobe_n,
  output logic wr_strobe_n
);

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} state_t;
  state_t state;
  state_t next_state;
  logic [2:0] expansion_mode_field;
  logic [7:0] low_port_out;
  logic [7:0] up_port_out;
  logic [7:0] up_port_dir;
  logic dp_pend;
  logic dp_write;
  logic dp_ok;
  logic [7:0] dp_addr;
  logic wr_en;
  logic [31:0] rd_word;
  logic [7:0] memory_map_register;
  logic expanding;
  logic low_drive;
  logic [15:0] mask;
  logic [3:0] npins;
  logic ext_hit;
  logic [15:0] masked_addr;
  logic [15:0] lat_addr;
  logic lat_wr;
  logic [7:0] lat_wdata;
  logic [15:0] shown_addr;

  // ----------------------------------------------------------------
  // Register bus slave, one wait state on every transfer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      dp_pend <= 1'b0;
      dp_write <= 1'b0;
      dp_ok <= 1'b0;
      dp_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (!dp_pend && hsel && htrans[1] && hready) begin
      dp_pend <= 1'b1;
      dp_write <= hwrite;
      dp_ok <= (haddr[31:8] == 24'h000000) && (hsize == SIZE_WORD);
      dp_addr <= haddr[7:0];
      hreadyout <= 1'b0;
    end else if (dp_pend) begin
      dp_pend <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  assign wr_en = dp_pend && dp_write && dp_ok;
  assign memory_map_register = {4'h0, onchip_ram_enable, expansion_mode_field};
  always_comb begin
    rd_word = 32'h00000000;
    if (dp_ok) begin
      case (dp_addr)
        OFF_MAP: rd_word = {24'h000000, memory_map_register};
        OFF_LOW_OUT: rd_word = {24'h000000, low_port_out};
        OFF_UP_OUT: rd_word = {24'h000000, up_port_out};
        OFF_UP_DIR: rd_word = {24'h000000, up_port_dir};
        OFF_PINS: rd_word = {16'h0000, upper_address_port_pins_i, muxed_bus_port_pins_i};
        OFF_STATUS: rd_word = {31'h00000000, state != ST_IDLE};
        default: rd_word = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (dp_pend && !dp_write) begin
      hrdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Mapping register and port latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || hw_stop) begin
      expansion_mode_field <= MODE_SC_IN;
    end else if (wr_en && dp_addr == OFF_MAP) begin
      expansion_mode_field <= hwdata[MODE_MSB:MODE_LSB];
    end
  end
  // No reset on purpose: survives reset, undefined until software writes it
  always_ff @(posedge clk) begin
    if (wr_en && dp_addr == OFF_MAP) begin
      onchip_ram_enable <= hwdata[RAM_EN_BIT];
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      low_port_out <= PORT_RESET;
      up_port_out <= PORT_RESET;
      up_port_dir <= PORT_RESET;
    end else if (wr_en) begin
      if (dp_addr == OFF_LOW_OUT) begin
        low_port_out <= hwdata[7:0];
      end
      if (dp_addr == OFF_UP_OUT) begin
        up_port_out <= hwdata[7:0];
      end
      if (dp_addr == OFF_UP_DIR) begin
        up_port_dir <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Undefined codes fall back to the safe input-port setting
  always_comb begin
    expanding = 1'b0;
    low_drive = 1'b0;
    mask = MASK_256;
    npins = PINS_256;
    case (expansion_mode_field)
      MODE_SC_OUT: low_drive = 1'b1;
      MODE_EXP_256: expanding = 1'b1;
      MODE_EXP_4K: begin
        expanding = 1'b1;
        mask = MASK_4K;
        npins = PINS_4K;
      end
      MODE_EXP_16K: begin
        expanding = 1'b1;
        mask = MASK_16K;
        npins = PINS_16K;
      end
      MODE_EXP_FULL: begin
        expanding = 1'b1;
        mask = MASK_FULL;
        npins = PINS_FULL;
      end
      default: expanding = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // External access sequencer
  // ----------------------------------------------------------------
  assign ext_hit = (core_req.rd || core_req.wr) && core_req.addr >= EXT_BASE
                   && core_req.addr <= EXT_TOP;
  assign masked_addr = core_req.addr & mask;
  assign shown_addr = (state == ST_IDLE) ? masked_addr : lat_addr;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (ext_hit && !core_resp.done && expanding) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: next_state = ST_DATA;
      ST_DATA: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Done blocks a restart for one cycle so the core can drop its request
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      lat_addr <= 16'h0000;
      lat_wr <= 1'b0;
      lat_wdata <= 8'h00;
      core_resp <= '0;
    end else begin
      state <= next_state;
      core_resp.done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (ext_hit && !core_resp.done) begin
            if (expanding) begin
              lat_addr <= masked_addr;
              lat_wr <= core_req.wr;
              lat_wdata <= core_req.wdata;
            end else begin
              core_resp.done <= 1'b1;
              core_resp.rdata <= NO_BUS_DATA;
            end
          end
        end
        ST_DATA: begin
          core_resp.done <= 1'b1;
          if (!lat_wr) begin
            core_resp.rdata <= muxed_bus_port_pins_i;
          end
        end
        default: core_resp.done <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Lower port pins and strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      muxed_bus_port_pins_o <= 8'h00;
      muxed_bus_port_pins_oe_n <= 8'hff;
      ale <= 1'b0;
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
    end else begin
      ale <= next_state == ST_ADDR;
      rd_strobe_n <= !(next_state == ST_DATA && !lat_wr);
      wr_strobe_n <= !(next_state == ST_DATA && lat_wr);
      if (expanding && next_state == ST_DATA) begin
        muxed_bus_port_pins_o <= lat_wdata;
        muxed_bus_port_pins_oe_n <= lat_wr ? 8'h00 : 8'hff;
      end else if (expanding) begin
        muxed_bus_port_pins_o <= (next_state == ST_ADDR) ? masked_addr[7:0]
                                                         : shown_addr[7:0];
        muxed_bus_port_pins_oe_n <= 8'h00;
      end else if (low_drive) begin
        muxed_bus_port_pins_o <= low_port_out;
        muxed_bus_port_pins_oe_n <= 8'h00;
      end else begin
        muxed_bus_port_pins_o <= 8'h00;
        muxed_bus_port_pins_oe_n <= 8'hff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Upper address / port pins
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_upper
    always_ff @(posedge clk) begin
      if (srst) begin
        upper_address_port_pins_o[i] <= 1'b0;
        upper_address_port_pins_oe_n[i] <= 1'b1;
      end else if (expanding && i < npins) begin
        upper_address_port_pins_o[i] <= shown_addr[8+i];
        upper_address_port_pins_oe_n[i] <= 1'b0;
      end else begin
        upper_address_port_pins_o[i] <= up_port_out[i];
        upper_address_port_pins_oe_n[i] <= ~up_port_dir[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  mode_clear_a: assert property (hw_stop |=> expansion_mode_field == MODE_SC_IN)
    else $error("mode field not cleared by hardware stop");
  lower_float_a: assert property ($past(expansion_mode_field) == MODE_SC_IN
                                  |-> muxed_bus_port_pins_oe_n == 8'hff)
    else $error("lower port not floating in input mode");
  strobe_mem_a: assert property ((!rd_strobe_n || !wr_strobe_n) |-> state == ST_DATA)
    else $error("strobe outside a memory cycle");
  addr_each_a: assert property ((expanding && state == ST_IDLE && next_state == ST_IDLE)
      |=> muxed_bus_port_pins_oe_n == 8'h00
          && muxed_bus_port_pins_o == $past(masked_addr[7:0]))
    else $error("address byte missing in idle cycle");
  no_high_a: assert property (expansion_mode_field == MODE_EXP_256
      |=> upper_address_port_pins_oe_n == ~$past(up_port_dir))
    else $error("upper pin driven in 256-byte mode");
  four_k_a: assert property (expansion_mode_field == MODE_EXP_4K
      |=> upper_address_port_pins_oe_n[3:0] == 4'h0
          && upper_address_port_pins_o[3:0] == $past(shown_addr[11:8])
          && upper_address_port_pins_o[7:4] == $past(up_port_out[7:4]))
    else $error("4K mode pin assignment wrong");
  sixteen_a: assert property (expansion_mode_field == MODE_EXP_16K
      |=> upper_address_port_pins_oe_n[5:0] == 6'h00
          && upper_address_port_pins_oe_n[7:6] == ~$past(up_port_dir[7:6]))
    else $error("16K mode pin assignment wrong");
  full_pins_a: assert property (expansion_mode_field == MODE_EXP_FULL
      |=> upper_address_port_pins_oe_n == 8'h00
          && upper_address_port_pins_o == $past(shown_addr[15:8]))
    else $error("full mode upper pins wrong");
  mux_addr_a: assert property (ale |-> muxed_bus_port_pins_o == lat_addr[7:0]
                               && (lat_addr & ~mask) == 16'h0000)
    else $error("latched address not masked to mode size");
  cycle_len_a: assert property ((state == ST_IDLE && next_state == ST_ADDR)
      |=> ale ##1 !ale ##1 core_resp.done)
    else $error("external cycle length wrong");

endmodule

// >>> test/ext_bus_memory_model.sv
// Behavioural memory on the multiplexed external bus
`timescale 1ns/1ps
module ext_bus_memory_model (
  input wire logic clk,
  input wire logic ale,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic [7:0] lower_o,
  input wire logic [7:0] lower_oe_n,
  input wire logic [7:0] upper_o,
  output logic [7:0] lower_wire
);
  logic [15:0] latched_addr = 16'h0000;
  logic [7:0] last_level = 8'h00;
  logic [7:0] mem [0:255];
  logic [7:0] idx;
  // ----------------------------------------------------------------
  // Address latch and storage
  // ----------------------------------------------------------------
  assign idx = latched_addr[7:0] ^ latched_addr[15:8];
  always @(posedge clk) begin
    if (ale) begin
      latched_addr <= {upper_o, lower_o};
    end
    if (!wr_strobe_n) begin
      mem[idx] <= lower_wire;
    end
    last_level <= lower_wire;
  end
  // Released lines show memory under a read strobe, else the inverse of the last level, never a stale copy
  assign lower_wire = (lower_o & ~lower_oe_n) |
    ((rd_strobe_n ? ~last_level : mem[idx]) & lower_oe_n);
endmodule

// >>> test/external_memory_expansion_control_test.sv
// Self-checking bench for the external memory expansion controller
`timescale 1ns/1ps
module external_memory_expansion_control_test;
  import ext_exp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hw_stop = 1'b0;
  core_req_t core_req = '0;
  core_resp_t core_resp;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, onchip_ram_enable;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = SIZE_WORD;
  logic [7:0] lower_i, lower_o, lower_oe_n, upper_i, upper_o, upper_oe_n;
  logic [7:0] upper_ext = 8'h3c, upl, dir, wd;
  logic ale, rd_strobe_n, wr_strobe_n;
  logic core_rd = 1'b0, rd_phase = 1'b0;
  logic [31:0] pin_q[$], ahb_q[$];
  logic [7:0] core_q[$];
  logic [15:0] a;
  int n_errors = 0, num_checks = 0, i;
  int seed = 32'ha3be;
  logic [2:0] x_mode [4] = '{MODE_EXP_256, MODE_EXP_4K, MODE_EXP_16K, MODE_EXP_FULL};
  logic [15:0] x_mask [4] = '{MASK_256, MASK_4K, MASK_16K, MASK_FULL};
  logic [7:0] x_pm [4] = '{8'h00, 8'h0f, 8'h3f, 8'hff};

  always #20 clk = ~clk;
  assign hready = hreadyout;
  assign upper_i = (upper_o & ~upper_oe_n) | (upper_ext & upper_oe_n);

  ext_mem_expansion dut (.clk(clk), .srst(srst), .hw_stop(hw_stop), .core_req(core_req),
    .core_resp(core_resp), .onchip_ram_enable(onchip_ram_enable), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .muxed_bus_port_pins_i(lower_i), .muxed_bus_port_pins_o(lower_o),
    .muxed_bus_port_pins_oe_n(lower_oe_n), .upper_address_port_pins_i(upper_i),
    .upper_address_port_pins_o(upper_o), .upper_address_port_pins_oe_n(upper_oe_n),
    .ale(ale), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n));
  ext_bus_memory_model far_side (.clk(clk), .ale(ale), .rd_strobe_n(rd_strobe_n),
    .wr_strobe_n(wr_strobe_n), .lower_o(lower_o), .lower_oe_n(lower_oe_n),
    .upper_o(upper_o), .lower_wire(lower_i));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Bounded wait for hreadyout (sel 0) or core done (sel 1)
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel ? core_resp.done : hreadyout) !== 1'b1 && n < 40);
    if (n >= 40) n_errors++;
  endtask
  // For reads d is the expected word
  task automatic ahb(input logic w, input logic [7:0] off, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, off};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= SIZE_WORD;
    wait_for(0);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_phase <= !w;
    if (!w) ahb_q.push_back(d);
    wait_for(0);
    rd_phase <= 1'b0;
  endtask
  task automatic core(input logic r, input logic [15:0] addr, input logic [7:0] d,
                      input logic [7:0] exp);
    @(posedge clk);
    core_req <= '{addr: addr, rd: r, wr: !r, wdata: d};
    core_rd <= r;
    if (r) core_q.push_back(exp);
    wait_for(1);
    core_req <= '0;
  endtask
  function automatic logic [31:0] pins(input logic [15:0] addr, input logic [15:0] mask,
                                       input logic [7:0] pm);
    logic [15:0] e;
    e = addr & mask;
    return {8'h00, ~(dir | pm), (e[15:8] & pm) | (upl & ~pm), e[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_phase && hreadyout === 1'b1) check(hrdata, ahb_q.pop_front());
    if (rd_phase) check(hresp, 32'h0);
    if (core_resp.done === 1'b1 && core_rd) check(core_resp.rdata, core_q.pop_front());
    // An address phase nobody asked for is a mismatch by itself
    if (!srst && ale !== 1'b0) begin
      check(32'(pin_q.size() != 0), 32'h1);
      if (pin_q.size() != 0) begin
        check({lower_oe_n, upper_oe_n, upper_o, lower_o},
              pin_q.pop_front());
      end
    end
  end

  // Run is some 250 cycles; the limit leaves ample margin
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(lower_oe_n, 8'hff);
    ahb(1, OFF_MAP, 32'hff);
    ahb(0, OFF_MAP, 32'h0f);
    ahb(1, 8'h18, 32'h55);
    ahb(0, 8'h18, 32'h0);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    ahb(0, OFF_MAP, 32'h08);
    check(onchip_ram_enable, 1'b1);
    ahb(1, OFF_MAP, 32'h07);
    @(posedge clk);
    hw_stop <= 1'b1;
    @(posedge clk);
    hw_stop <= 1'b0;
    ahb(0, OFF_MAP, 32'h00);
    ahb(1, OFF_LOW_OUT, 32'h5a);
    for (i = 0; i < 8; i++) begin
      wd = 8'($random(seed));
      wd[2:0] = 3'(i);
      ahb(1, OFF_MAP, {24'h0, wd}); // Only while the core bus is idle
      ahb(0, OFF_MAP, {28'h0, wd[3:0]});
      check(lower_oe_n, (i inside {0, 3, 5}) ? 8'hff : 8'h00);
      if (i == 1) check(lower_o, 8'h5a);
    end
    // Each device sits in an aligned area of its size, 8000H up for 16K
    for (i = 0; i < 4; i++) begin
      upl = 8'($random(seed));
      dir = 8'($random(seed));
      ahb(1, OFF_UP_OUT, {24'h0, upl});
      ahb(1, OFF_UP_DIR, {24'h0, dir});
      ahb(1, OFF_MAP, {29'h0, x_mode[i]});
      a = 16'h8000 | (16'($random(seed)) & 16'h73ff);
      wd = 8'($random(seed));
      pin_q.push_back(pins(a, x_mask[i], x_pm[i]));
      core(1'b0, a, wd, 8'h00);
      a = a ^ (16'h4000 & ~x_mask[i]);
      pin_q.push_back(pins(a, x_mask[i], x_pm[i]));
      core(1'b1, a, 8'h00, wd);
    end
    @(posedge clk);
    core_req <= '{addr: 16'h9a5c, default: '0};
    repeat (2) @(posedge clk);
    check({lower_o, upper_o, ale, rd_strobe_n, wr_strobe_n}, {8'h5c, 8'h9a, 3'b011});
    core_req <= '{addr: 16'h7fff, rd: 1'b1, default: '0};
    repeat (6) begin
      @(posedge clk);
      check({ale, core_resp.done}, 2'b00);
    end
    core_req <= '0;
    ahb(1, OFF_MAP, {29'h0, MODE_SC_OUT});
    core(1'b1, 16'h8001, 8'h00, NO_BUS_DATA);
    ahb(0, OFF_PINS, {16'h0, (upl & dir) | (upper_ext & ~dir), 8'h5a});
    ahb(0, OFF_STATUS, 32'h0);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
